// ### src/pfc_pkg.sv
package pfc_pkg;
    // Pin widths and last address
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam logic [17:0] LAST_ADDR = 18'h3FFFF;

    // Command bytes and data patterns
    localparam logic [7:0] CMD_SET_READ = 8'h00;
    localparam logic [7:0] CMD_SIGNATURE = 8'h90;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] PREPROG_BYTE = 8'h00;

    // Retry limits
    localparam int MAX_PROG_TRIES = 25;
    localparam int MAX_ERASE_TRIES = 1000;

    // Times in ns and their cycle counts
    localparam int CLK_NS = 20;
    localparam int WE_PULSE_NS = 40;
    localparam int WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_NS = 120;
    localparam int ACC_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int VPP_SETUP_NS = 100;
    localparam int VPP_CYC = (VPP_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_PULSE_NS = 10000;
    localparam int PROG_CYC = (PROG_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_NS = 6000;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_PULSE_NS = 9500000;
    localparam int ERASE_CYC = (ERASE_PULSE_NS + CLK_NS - 1) / CLK_NS;

    // Operations offered to the user side
    typedef enum logic [2:0] {
        OP_READ,
        OP_PROGRAM,
        OP_ERASE,
        OP_SIG_CMD,
        OP_SIG_HW,
        OP_RESET
    } pfc_op_type;
endpackage

// ### src/pfc_cycle.sv
module pfc_cycle (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic write,
    input wire logic [17:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] data_in,
    output logic done,
    output logic [7:0] rdata,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [17:0] addr_out,
    output logic [7:0] data_out,
    output logic data_oe
);
    typedef enum {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_ACCESS, C_END} pfc_cyc_type;

    pfc_cyc_type state;
    logic is_write;
    logic [3:0] cnt;

    ////////////////////////////////////////////////////////////////////////////
    // One bus cycle: write strobes we_n, read strobes oe_n
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= C_IDLE;
            is_write <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
            rdata <= 8'h00;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            addr_out <= 18'h00000;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            cnt <= cnt + 4'h1;
            case (state)
                C_IDLE: begin
                    if (start) begin
                        is_write <= write;
                        addr_out <= addr;
                        data_out <= wdata;
                        data_oe <= write;
                        ce_n <= 1'b0;
                        oe_n <= write; // Read: ce and oe low, we high
                        state <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    cnt <= 4'h0;
                    if (is_write) begin
                        we_n <= 1'b0; // Device latches address on falling edge
                        state <= C_STROBE;
                    end else begin
                        state <= C_ACCESS;
                    end
                end
                C_STROBE: begin
                    if (cnt == 4'(pfc_pkg::WE_CYC - 1)) begin
                        we_n <= 1'b1; // Byte taken on rising edge
                        state <= C_HOLD;
                    end
                end
                C_HOLD: begin
                    state <= C_END;
                end
                C_ACCESS: begin
                    if (cnt == 4'(pfc_pkg::ACC_CYC - 1)) begin
                        rdata <= data_in;
                        state <= C_END;
                    end
                end
                C_END: begin
                    ce_n <= 1'b1;
                    oe_n <= 1'b1;
                    data_oe <= 1'b0;
                    done <= 1'b1;
                    state <= C_IDLE;
                end
                default: begin
                    state <= C_IDLE;
                end
            endcase
        end
    end
endmodule

// ### src/pfc_host.sv
// Function
// - Read with ce, oe low, we high
// - Set-read command at the end, before supply drops
// - Erase 20H twice, program 40H+data, reset FFH twice
// - 90H signature, A0H erase verify, C0H program verify
// - Hardware signature: high line 9, others low
// - Wait 10us pulse plus 6us before read
// - At most 25 program tries per byte
// - Program every byte to 00H before erase
// - Erase verify every byte, advancing addresses
module pfc_host #(
    parameter int ERASE_CYC = pfc_pkg::ERASE_CYC,
    parameter logic [17:0] LAST_ADDR = pfc_pkg::LAST_ADDR
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire pfc_pkg::pfc_op_type op,
    input wire logic [17:0] addr,
    input wire logic [7:0] wdata,
    output logic busy,
    output logic done,
    output logic ok,
    output logic [7:0] rdata,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic vpp_high,
    output logic sig_hv,
    output logic [17:0] address_inputs,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic [7:0] data_lines_in
);
    typedef enum {
        S_IDLE, S_VSET, S_RD, S_SIG_W, S_SIG_RD, S_P_CMD, S_P_DATA, S_P_PULSE, S_P_VCMD, S_P_REC, S_P_RD,
        S_E_CMD1, S_E_CMD2, S_E_PULSE, S_E_VCMD, S_E_REC, S_E_RD, S_R_CMD1, S_R_CMD2, S_SETREAD, S_DONE, S_SIG_REC
    } pfc_state_type;

    pfc_state_type state;
    pfc_pkg::pfc_op_type op_q;
    logic [17:0] addr_q;
    logic [7:0] data_q;
    logic preprog;
    logic [4:0] tries;
    logic [9:0] etries;
    logic [18:0] wait_cnt;
    logic issued;
    logic req_wr;
    logic req_rd;
    logic [17:0] req_addr;
    logic [7:0] req_data;
    logic [18:0] wait_end;
    logic wait_hit;
    logic cyc_done;
    logic [7:0] cyc_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Bus request for the current state
    always_comb begin
        req_wr = 1'b0;
        req_rd = 1'b0;
        req_addr = addr_q;
        req_data = pfc_pkg::CMD_SET_READ;
        case (state)
            S_RD: req_rd = 1'b1; // Plain read, supply low: no command
            S_SIG_W: begin
                req_wr = 1'b1;
                req_data = pfc_pkg::CMD_SIGNATURE;
            end
            S_SIG_RD: begin
                req_rd = 1'b1;
                req_addr = {17'h00000, addr_q[0]};
            end
            S_P_CMD: begin
                req_wr = 1'b1;
                req_data = pfc_pkg::CMD_PROGRAM;
            end
            S_P_DATA: begin
                req_wr = 1'b1;
                req_data = data_q;
            end
            S_P_VCMD: begin
                req_wr = 1'b1;
                req_data = pfc_pkg::CMD_PROG_VERIFY;
            end
            S_P_RD, S_E_RD: req_rd = 1'b1;
            S_E_CMD1, S_E_CMD2: begin
                req_wr = 1'b1;
                req_data = pfc_pkg::CMD_ERASE;
            end
            S_E_VCMD: begin
                req_wr = 1'b1;
                req_data = pfc_pkg::CMD_ERASE_VERIFY;
            end
            S_R_CMD1, S_R_CMD2: begin
                req_wr = 1'b1;
                req_data = pfc_pkg::CMD_RESET;
            end
            S_SETREAD: req_wr = 1'b1; // Back to read mode
            default: req_wr = 1'b0;
        endcase
    end

    // Wait lengths for timed states
    always_comb begin
        case (state)
            S_VSET: wait_end = 19'(pfc_pkg::VPP_CYC);
            S_P_PULSE: wait_end = 19'(pfc_pkg::PROG_CYC);
            S_P_REC, S_E_REC, S_SIG_REC: wait_end = 19'(pfc_pkg::RECOVER_CYC);
            S_E_PULSE: wait_end = 19'(ERASE_CYC);
            default: wait_end = 19'h00001;
        endcase
    end
    assign wait_hit = (wait_cnt == wait_end - 19'h00001);

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle engine
    pfc_cycle u_cycle (
        .clock(clock),
        .rst(rst),
        .start((req_wr | req_rd) & ~issued),
        .write(req_wr),
        .addr(req_addr),
        .wdata(req_data),
        .data_in(data_lines_in),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .addr_out(address_inputs),
        .data_out(data_lines_out),
        .data_oe(data_lines_oe)
    );

    // One launch per bus state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            issued <= 1'b0;
        end else if (cyc_done) begin
            issued <= 1'b0;
        end else if (req_wr | req_rd) begin
            issued <= 1'b1;
        end
    end

    // Wait counter, restarts when the wait length is reached and while idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_cnt <= 19'h00000;
        end else if (wait_hit || state == S_IDLE) begin
            wait_cnt <= 19'h00000;
        end else begin
            wait_cnt <= wait_cnt + 19'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            op_q <= pfc_pkg::OP_READ;
            addr_q <= 18'h00000;
            data_q <= 8'h00;
            preprog <= 1'b0;
            tries <= 5'h00;
            etries <= 10'h000;
            ok <= 1'b0;
            rdata <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            vpp_high <= 1'b0;
            sig_hv <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        op_q <= op;
                        addr_q <= addr;
                        data_q <= wdata;
                        tries <= 5'h00;
                        etries <= 10'h000;
                        ok <= 1'b0;
                        busy <= 1'b1;
                        vpp_high <= op != pfc_pkg::OP_READ && op != pfc_pkg::OP_SIG_HW;
                        sig_hv <= op == pfc_pkg::OP_SIG_HW;
                        state <= (op == pfc_pkg::OP_READ) ? S_RD : S_VSET;
                        if (op == pfc_pkg::OP_SIG_HW) begin
                            addr_q <= {17'h00000, addr[0]}; // Other lines low
                        end
                        if (op == pfc_pkg::OP_ERASE) begin
                            addr_q <= 18'h00000; // Preprogram pass first
                            data_q <= pfc_pkg::PREPROG_BYTE;
                            preprog <= 1'b1;
                        end
                    end
                end
                S_VSET: begin
                    if (wait_hit) begin
                        case (op_q)
                            pfc_pkg::OP_PROGRAM, pfc_pkg::OP_ERASE: state <= S_P_CMD;
                            pfc_pkg::OP_SIG_CMD: state <= S_SIG_W;
                            pfc_pkg::OP_SIG_HW: state <= S_RD;
                            default: state <= S_R_CMD1;
                        endcase
                    end
                end
                S_RD, S_SIG_RD: begin
                    if (cyc_done) begin
                        rdata <= cyc_rdata;
                        ok <= 1'b1;
                        state <= (state == S_SIG_RD) ? S_SETREAD : S_DONE;
                    end
                end
                S_SIG_W: if (cyc_done) state <= S_SIG_REC;
                S_SIG_REC: if (wait_hit) state <= S_SIG_RD; // Write recovery before read
                S_P_CMD: if (cyc_done) state <= S_P_DATA;
                S_P_DATA: if (cyc_done) state <= S_P_PULSE;
                S_P_PULSE: if (wait_hit) state <= S_P_VCMD;
                S_P_VCMD: if (cyc_done) state <= S_P_REC;
                S_P_REC: if (wait_hit) state <= S_P_RD;
                S_P_RD: begin
                    if (cyc_done) begin
                        rdata <= cyc_rdata;
                        if (cyc_rdata != data_q) begin
                            tries <= tries + 5'h01;
                            // Give up after the last allowed try
                            state <= (tries == 5'(pfc_pkg::MAX_PROG_TRIES - 1)) ? S_SETREAD : S_P_CMD;
                        end else if (!preprog) begin
                            ok <= 1'b1;
                            state <= S_SETREAD;
                        end else if (addr_q == LAST_ADDR) begin
                            preprog <= 1'b0; // Every byte is 00H now
                            addr_q <= 18'h00000;
                            state <= S_E_CMD1;
                        end else begin
                            addr_q <= addr_q + 18'h00001;
                            tries <= 5'h00;
                            state <= S_P_CMD;
                        end
                    end
                end
                S_E_CMD1: if (cyc_done) state <= S_E_CMD2;
                S_E_CMD2: if (cyc_done) state <= S_E_PULSE;
                S_E_PULSE: if (wait_hit) state <= S_E_VCMD;
                S_E_VCMD: if (cyc_done) state <= S_E_REC;
                S_E_REC: if (wait_hit) state <= S_E_RD;
                S_E_RD: begin
                    if (cyc_done) begin
                        rdata <= cyc_rdata;
                        if (cyc_rdata != pfc_pkg::ERASED_BYTE) begin
                            // Pulse again, resume at this byte
                            etries <= etries + 10'h001;
                            state <= (etries == 10'(pfc_pkg::MAX_ERASE_TRIES - 1)) ? S_SETREAD : S_E_CMD1;
                        end else if (addr_q == LAST_ADDR) begin
                            ok <= 1'b1;
                            state <= S_SETREAD;
                        end else begin
                            addr_q <= addr_q + 18'h00001;
                            state <= S_E_VCMD;
                        end
                    end
                end
                S_R_CMD1: if (cyc_done) state <= S_R_CMD2;
                S_R_CMD2: begin
                    if (cyc_done) begin
                        ok <= 1'b1;
                        state <= S_SETREAD;
                    end
                end
                S_SETREAD: if (cyc_done) state <= S_DONE;
                S_DONE: begin
                    vpp_high <= 1'b0;
                    sig_hv <= 1'b0;
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [7:0] last_wr;
    logic [9:0] since_we;
    logic [9:0] since_pdata;

    // Last written byte and cycles since write strobe rise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_wr <= 8'h00;
            since_we <= 10'h3FF;
            since_pdata <= 10'h3FF;
        end else begin
            if (!we_n) begin
                last_wr <= data_lines_out;
                since_we <= 10'h000;
            end else if (since_we != 10'h3FF) begin
                since_we <= since_we + 10'h001;
            end
            if (!we_n && state == S_P_DATA) begin
                since_pdata <= 10'h000;
            end else if (since_pdata != 10'h3FF) begin
                since_pdata <= since_pdata + 10'h001;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence erase_first_s;
        state == S_E_CMD1 && cyc_done;
    endsequence
    sequence erase_second_s;
        state == S_E_CMD2 && cyc_done;
    endsequence

    read_strobe_a: assert property (!oe_n |-> !ce_n && we_n && !data_lines_oe)
        else $error("read strobe without proper pin levels");
    write_strobe_a: assert property (!we_n |-> !ce_n && oe_n && data_lines_oe)
        else $error("write strobe without proper pin levels");
    setread_end_a: assert property ($fell(vpp_high) |-> last_wr == pfc_pkg::CMD_SET_READ)
        else $error("supply dropped without set-read command");
    erase_pair_a: assert property (erase_first_s ##7 erase_second_s |=> state == S_E_PULSE [*3])
        else $error("erase pulse not timed after two erase commands");
    sig_lines_a: assert property (sig_hv && !oe_n |-> address_inputs[17:1] == 17'h00000)
        else $error("address lines not low in hardware signature");
    recovery_gap_a: assert property (vpp_high && $fell(oe_n) |-> since_we >= 10'(pfc_pkg::RECOVER_CYC))
        else $error("read too soon after write");
    prog_gap_a: assert property (state == S_P_RD && $fell(oe_n)
        |-> since_pdata >= 10'(pfc_pkg::PROG_CYC + pfc_pkg::RECOVER_CYC))
        else $error("program verify read too soon");
    retry_limit_a: assert property (state == S_P_CMD |-> tries < 5'(pfc_pkg::MAX_PROG_TRIES))
        else $error("program retried beyond limit");
    preprog_first_a: assert property (state == S_E_CMD1 |-> !preprog)
        else $error("erase begun before preprogramming");
    erase_walk_a: assert property (state == S_E_RD && cyc_done && cyc_rdata == pfc_pkg::ERASED_BYTE
        && addr_q != LAST_ADDR |=> addr_q == $past(addr_q) + 18'h00001)
        else $error("erase verify did not advance");
endmodule

// ### tb/pfc_flash_model.sv
module pfc_flash_model #(
    parameter int LAST = 3,
    parameter logic [7:0] MFG_CODE = 8'h5E, // Arbitrary maker code
    parameter logic [7:0] DEV_CODE = 8'hC3 // Arbitrary part code
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic vpp_high,
    input wire logic sig_hv,
    input wire logic [17:0] address_inputs,
    input wire logic [7:0] data_lines_out,
    input wire logic data_lines_oe,
    input var int weak_prog,
    input var int weak_erase,
    output logic [7:0] data_lines_in,
    output logic fault,
    output int tries,
    output int erase_pulses
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:LAST];
    logic [7:0] cmd = 8'h00; // Power-up read mode
    logic [17:0] lat_a = 18'h00000;
    logic [17:0] pa = 18'h3FFFF;
    logic [7:0] q;
    logic drv;
    logic flip = 1'b0;
    realtime t_prog = 0;
    ////////////////////////////////////////////////////////////////
    // Array contents and released-bus pattern
    initial begin
        fault = 1'b0;
        tries = 0;
        erase_pulses = 0;
        foreach (mem[i]) mem[i] = 8'hF0 | 8'(i);
        forever #10 flip = ~flip;
    end
    // Address latch on strobe fall
    always @(negedge we_n) if (!ce_n) lat_a = address_inputs;
    // Command capture on strobe rise, program timer starts on data byte
    always @(posedge we_n) begin
        if (!ce_n && vpp_high) begin
            if (cmd == 8'h40) begin
                tries = (lat_a == pa) ? tries + 1 : 1;
                pa = lat_a;
                if (tries > 25) fault = 1'b1;
                if (tries > weak_prog) mem[lat_a] = mem[lat_a] & data_lines_out;
                t_prog = $realtime;
                cmd = 8'h41;
            end else if (cmd == 8'h20 && data_lines_out == 8'h20) begin
                // Bytes must be all zero before the first pulse
                if (erase_pulses == 0) foreach (mem[i]) if (mem[i] != 8'h00) fault = 1'b1;
                foreach (mem[i]) if (erase_pulses >= weak_erase || i != LAST) mem[i] = 8'hFF;
                erase_pulses++;
                cmd = 8'h21;
            end else if (cmd == 8'hFF && data_lines_out == 8'hFF) begin
                cmd = 8'h00;
            end else begin
                cmd = data_lines_out;
            end
        end
    end
    // Read data selection
    always_comb begin
        drv = !ce_n && !oe_n && we_n;
        if (sig_hv || cmd == 8'h90) q = address_inputs[0] ? DEV_CODE : MFG_CODE;
        else if (cmd == 8'hA0) q = mem[lat_a];
        else if (cmd == 8'hC0) q = mem[pa];
        else q = mem[address_inputs];
    end
    // Wire level from both parties, pattern when nobody drives
    assign data_lines_in = drv ? q : (data_lines_oe ? data_lines_out : ({8{flip}} ^ 8'hA5));
    // Host sequencing checks at read start
    always @(negedge oe_n) begin
        #1; // Let chip select and address of the same edge settle
        if (!ce_n) begin
            if (cmd == 8'hC0 && $realtime - t_prog < 16000) fault = 1'b1;
            if (vpp_high && !sig_hv && !(cmd inside {8'h00, 8'h90, 8'hA0, 8'hC0})) fault = 1'b1;
            if (sig_hv && address_inputs[17:1] != 17'h00000) fault = 1'b1;
        end
    end
endmodule

// ### tb/tb_parallel_flash_command_port.sv
module tb_parallel_flash_command_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MFG = 8'h5E; // Arbitrary maker code
    localparam logic [7:0] DEV = 8'hC3; // Arbitrary part code
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    pfc_pkg::pfc_op_type op = pfc_pkg::OP_READ;
    logic [17:0] addr = 18'h00000;
    logic [7:0] wdata = 8'h00;
    logic busy, done, ok, ce_n, oe_n, we_n, vpp_high, sig_hv, data_lines_oe, fault;
    logic [7:0] rdata, data_lines_out, data_lines_in;
    logic [17:0] address_inputs;
    int weak_prog = 0;
    int weak_erase = 0;
    int tries, erase_pulses, cyc;
    int n_errors = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////////
    // Design and device model
    pfc_host #(.ERASE_CYC(20), .LAST_ADDR(18'h00003)) u_dut (.clock(clock), .rst(rst), .start(start),
        .op(op), .addr(addr), .wdata(wdata), .busy(busy), .done(done), .ok(ok), .rdata(rdata),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .vpp_high(vpp_high), .sig_hv(sig_hv),
        .address_inputs(address_inputs), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in));
    pfc_flash_model #(.LAST(3), .MFG_CODE(MFG), .DEV_CODE(DEV)) u_flash (.ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .vpp_high(vpp_high), .sig_hv(sig_hv), .address_inputs(address_inputs),
        .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .weak_prog(weak_prog),
        .weak_erase(weak_erase), .data_lines_in(data_lines_in), .fault(fault), .tries(tries),
        .erase_pulses(erase_pulses));
    // Clock
    initial forever #10 clock = ~clock;
    ////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One operation, cycles counted from the start edge
    task automatic run(input pfc_pkg::pfc_op_type o, input logic [17:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        start = 1'b1;
        op = o;
        addr = a;
        wdata = d;
        @(posedge clock);
        #1;
        start = 1'b0;
        cyc = 0;
        while (done !== 1'b1 && cyc < 40000) begin
            @(posedge clock);
            #1;
            cyc++;
        end
        if (done !== 1'b1) begin
            n_errors++;
            results();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        check({busy, done, ok, ce_n, oe_n, we_n, vpp_high, sig_hv, data_lines_oe}, 32'h038);
        check(address_inputs, 32'h00000);
        check(rdata, 32'h00);
    endtask
    task automatic t_read;
        for (int a = 0; a < 4; a++) begin
            run(pfc_pkg::OP_READ, 18'(a), 8'h00);
            check(cyc, 32'h0B);
            check(rdata, 32'(8'hF0 | 8'(a)));
            check(ok, 32'h1);
        end
    endtask
    task automatic t_signature;
        for (int m = 0; m < 4; m++) begin
            run(m < 2 ? pfc_pkg::OP_SIG_CMD : pfc_pkg::OP_SIG_HW, 18'(m % 2), 8'h00);
            check(rdata, 32'((m % 2) ? DEV : MFG));
        end
    endtask
    task automatic t_program;
        run(pfc_pkg::OP_PROGRAM, 18'h00002, 8'h30);
        check({ok, tries[7:0]}, 32'h101);
        weak_prog = 3;
        run(pfc_pkg::OP_PROGRAM, 18'h00001, 8'h51);
        check({ok, rdata, tries[7:0]}, 32'h15104);
        weak_prog = 99;
        run(pfc_pkg::OP_PROGRAM, 18'h00003, 8'h00);
        check({ok, tries[7:0]}, 32'h019);
        weak_prog = 0;
        run(pfc_pkg::OP_READ, 18'h00002, 8'h00);
        check(rdata, 32'h30);
    endtask
    task automatic t_erase;
        weak_erase = 1;
        run(pfc_pkg::OP_ERASE, 18'h00000, 8'h00);
        check({ok, erase_pulses[7:0]}, 32'h102);
        for (int a = 0; a < 4; a++) begin
            run(pfc_pkg::OP_READ, 18'(a), 8'h00);
            check(rdata, 32'hFF);
        end
    endtask
    task automatic t_refused;
        run(pfc_pkg::OP_RESET, 18'h00000, 8'h00);
        check(vpp_high, 32'h0);
        @(posedge clock);
        #1;
        start = 1'b1;
        op = pfc_pkg::OP_SIG_HW;
        @(posedge clock);
        #1;
        start = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        start = 1'b1;
        op = pfc_pkg::OP_SIG_CMD;
        addr = 18'h00001;
        @(posedge clock);
        #1;
        start = 1'b0;
        cyc = 0;
        while (done !== 1'b1 && cyc < 200) begin
            @(posedge clock);
            #1;
            cyc++;
        end
        if (done !== 1'b1) begin
            n_errors++;
            results();
        end
        check(rdata, 32'(MFG));
        repeat (20) @(posedge clock);
        check(busy, 32'h0);
        check(fault, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        t_reset();
        t_read();
        t_signature();
        t_program();
        t_erase();
        t_refused();
        results();
    end
endmodule
